// File: hdl/mis_pkg.sv
// package for the metering event status block: register offsets, bit positions,
// write masks, reset values and the carrier structs.
// assumes one core clock; every event input comes from logic on that clock.
package mis_pkg;

   // special function register addresses
   localparam logic [7:0] MIS_ADDR_EN_LOW = 8'hD9;
   localparam logic [7:0] MIS_ADDR_EN_MID = 8'hDA;
   localparam logic [7:0] MIS_ADDR_EN_HIGH = 8'hDB;
   localparam logic [7:0] MIS_ADDR_ST_LOW = 8'hDC;
   localparam logic [7:0] MIS_ADDR_ST_MID = 8'hDD;
   localparam logic [7:0] MIS_ADDR_ST_HIGH = 8'hDE;

   // status low bit positions
   localparam int MIS_LOW_SUMMARY = 7;
   localparam int MIS_LOW_FAULT = 5;
   localparam int MIS_LOW_REACTIVE_SIGN = 4;
   localparam int MIS_LOW_ACTIVE_SIGN = 3;
   localparam int MIS_LOW_APPARENT_NOLOAD = 2;
   localparam int MIS_LOW_REACTIVE_NOLOAD = 1;
   localparam int MIS_LOW_ACTIVE_NOLOAD = 0;

   // status mid bit positions
   localparam int MIS_MID_FREQ_B = 7;
   localparam int MIS_MID_FREQ_A = 6;
   localparam int MIS_MID_OVERFLOW_LSB = 3;
   localparam int MIS_MID_HALF_LSB = 0;

   // status high bit positions
   localparam int MIS_HIGH_RESET_DONE = 7;
   localparam int MIS_HIGH_WAVEFORM = 5;
   localparam int MIS_HIGH_CURRENT_PEAK = 4;
   localparam int MIS_HIGH_VOLTAGE_PEAK = 3;
   localparam int MIS_HIGH_CYCLE_DONE = 2;
   localparam int MIS_HIGH_ZX_TIMEOUT = 1;
   localparam int MIS_HIGH_ZX_DETECT = 0;

   // accumulation configuration polarity bits
   localparam int MIS_ACC_FAULT_POL = 6;
   localparam int MIS_ACC_REACTIVE_POL = 5;
   localparam int MIS_ACC_ACTIVE_POL = 4;

   // implemented bits of each register
   localparam logic [7:0] MIS_MASK_EN_LOW = 8'h3F;
   localparam logic [7:0] MIS_MASK_EN_MID = 8'hFF;
   localparam logic [7:0] MIS_MASK_EN_HIGH = 8'h3F;
   localparam logic [7:0] MIS_MASK_ST_LOW = 8'h3F;
   localparam logic [7:0] MIS_MASK_ST_MID = 8'hFF;
   localparam logic [7:0] MIS_MASK_ST_HIGH = 8'hBF;

   // value after reset and read value of an unmapped address
   localparam logic [7:0] MIS_RESET_VALUE = 8'h00;
   localparam logic [7:0] MIS_RDATA_UNMAPPED = 8'h00;

   // events from the metering engine; energy index 2 apparent, 1 reactive, 0 active
   typedef struct packed {
      logic fault_mode;
      logic reactive_negative;
      logic active_negative;
      logic apparent_noload;
      logic irms_noload;
      logic reactive_noload;
      logic active_noload;
      logic freq_out_b_pulse;
      logic freq_out_a_pulse;
      logic [2:0] energy_overflow;
      logic [2:0] energy_half;
      logic waveform_sample_ready;
      logic current_peak;
      logic voltage_peak;
      logic line_cycle_done;
      logic zero_cross_timeout;
      logic zero_cross_detect;
   } mis_events_type;

   // one special function register access from the core
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } mis_sfr_req_type;

endpackage

// File: hdl/mis_edge_sel.sv
// direction-selectable transition detector for one engine level.
// assumes the level comes from logic on clk; it is not synchronised here.
`timescale 1ns/1ps
module mis_edge_sel
   import mis_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // level and chosen direction: 0 fires on a rise, 1 on a fall
   input wire logic level,
   input wire logic fall_sel,
   // one-cycle event
   output logic event_q
);

   logic level_q;
   logic level_d;
   logic event_d;

   // the previous level resets low, so a level already high at release counts as a rise
   always_comb begin
      level_d = level;
      event_d = fall_sel ? (level_q & ~level) : (~level_q & level);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level_q <= 1'b0;
         event_q <= 1'b0;
      end else begin
         level_q <= level_d;
         event_q <= event_d;
      end
   end

endmodule

// File: hdl/mis_status.sv
// metering event status and enable registers with the pending summary bit.
// assumes the core drives one access per cycle on clk and that every event
// input is produced by engine logic on the same clock.
`timescale 1ns/1ps

module mis_status
   import mis_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register access from the core
   input wire mis_sfr_req_type sfr_req,
   output logic [7:0] sfr_rdata,
   // software reset request, one cycle
   input wire logic soft_reset,
   // engine events and configuration
   input wire mis_events_type events,
   input wire logic [7:0] accumulation_config,
   // pending interrupt to the core
   output logic metering_irq_summary
);

   logic [7:0] st_low_q, st_low_d;
   logic [7:0] st_mid_q, st_mid_d;
   logic [7:0] st_high_q, st_high_d;
   logic [7:0] en_low_q, en_low_d;
   logic [7:0] en_mid_q, en_mid_d;
   logic [7:0] en_high_q, en_high_d;
   logic summary_q, summary_d;
   logic boot_q, boot_d;
   logic [7:0] rdata_q, rdata_d;
   logic fault_change_flag;
   logic reactive_sign_flag;
   logic active_sign_flag;
   logic [7:0] set_low, set_mid, set_high;

   // write strobe for one address
   function automatic logic wr_hit(input mis_sfr_req_type req, input logic [7:0] addr);
      return req.wr && (req.addr == addr);
   endfunction

   // bits a write clears: a zero written to an implemented flag clears it
   function automatic logic [7:0] clr_bits(input mis_sfr_req_type req, input logic [7:0] addr,
                                           input logic [7:0] mask);
      return wr_hit(req, addr) ? (~req.wdata & mask) : 8'h00;
   endfunction

   // any enabled flag set
   function automatic logic any_enabled(input logic [7:0] sl, input logic [7:0] sm,
                                        input logic [7:0] sh, input logic [7:0] el,
                                        input logic [7:0] em, input logic [7:0] eh);
      return |(sl & el & MIS_MASK_EN_LOW) | |(sm & em & MIS_MASK_EN_MID)
             | |(sh & eh & MIS_MASK_EN_HIGH);
   endfunction

   // sign and fault transition detectors
   mis_edge_sel u_fault_edge (
      .clk(clk),
      .rst_n(rst_n),
      .level(events.fault_mode),
      .fall_sel(accumulation_config[MIS_ACC_FAULT_POL]),
      .event_q(fault_change_flag)
   );

   mis_edge_sel u_reactive_edge (
      .clk(clk),
      .rst_n(rst_n),
      .level(events.reactive_negative),
      .fall_sel(accumulation_config[MIS_ACC_REACTIVE_POL]),
      .event_q(reactive_sign_flag)
   );

   mis_edge_sel u_active_edge (
      .clk(clk),
      .rst_n(rst_n),
      .level(events.active_negative),
      .fall_sel(accumulation_config[MIS_ACC_ACTIVE_POL]),
      .event_q(active_sign_flag)
   );

   // event set vectors
   always_comb begin
      set_low = 8'h00;
      set_low[MIS_LOW_FAULT] = fault_change_flag;
      set_low[MIS_LOW_REACTIVE_SIGN] = reactive_sign_flag;
      set_low[MIS_LOW_ACTIVE_SIGN] = active_sign_flag;
      set_low[MIS_LOW_APPARENT_NOLOAD] = events.apparent_noload | events.irms_noload;
      set_low[MIS_LOW_REACTIVE_NOLOAD] = events.reactive_noload;
      set_low[MIS_LOW_ACTIVE_NOLOAD] = events.active_noload;
      set_mid = 8'h00;
      // frequency pulses count whether or not the pin output is enabled
      set_mid[MIS_MID_FREQ_B] = events.freq_out_b_pulse;
      set_mid[MIS_MID_FREQ_A] = events.freq_out_a_pulse;
      set_mid[MIS_MID_OVERFLOW_LSB +: 3] = events.energy_overflow;
      set_mid[MIS_MID_HALF_LSB +: 3] = events.energy_half;
      set_high = 8'h00;
      set_high[MIS_HIGH_RESET_DONE] = ~boot_q;
      set_high[MIS_HIGH_WAVEFORM] = events.waveform_sample_ready;
      set_high[MIS_HIGH_CURRENT_PEAK] = events.current_peak;
      set_high[MIS_HIGH_VOLTAGE_PEAK] = events.voltage_peak;
      set_high[MIS_HIGH_CYCLE_DONE] = events.line_cycle_done;
      set_high[MIS_HIGH_ZX_TIMEOUT] = events.zero_cross_timeout;
      set_high[MIS_HIGH_ZX_DETECT] = events.zero_cross_detect;
   end

   // flag and enable next state; a set in the clearing cycle wins
   always_comb begin
      boot_d = 1'b1;
      st_low_d = ((st_low_q & ~clr_bits(sfr_req, MIS_ADDR_ST_LOW, MIS_MASK_ST_LOW))
                  | set_low) & MIS_MASK_ST_LOW;
      st_mid_d = ((st_mid_q & ~clr_bits(sfr_req, MIS_ADDR_ST_MID, MIS_MASK_ST_MID))
                  | set_mid) & MIS_MASK_ST_MID;
      st_high_d = ((st_high_q & ~clr_bits(sfr_req, MIS_ADDR_ST_HIGH, MIS_MASK_ST_HIGH))
                   | set_high) & MIS_MASK_ST_HIGH;
      en_low_d = wr_hit(sfr_req, MIS_ADDR_EN_LOW) ? (sfr_req.wdata & MIS_MASK_EN_LOW)
                                                  : en_low_q;
      en_mid_d = wr_hit(sfr_req, MIS_ADDR_EN_MID) ? (sfr_req.wdata & MIS_MASK_EN_MID)
                                                  : en_mid_q;
      en_high_d = wr_hit(sfr_req, MIS_ADDR_EN_HIGH) ? (sfr_req.wdata & MIS_MASK_EN_HIGH)
                                                    : en_high_q;
      // software reset clears the flags and enables and leaves only the reset mark
      if (soft_reset) begin
         st_low_d = MIS_RESET_VALUE;
         st_mid_d = MIS_RESET_VALUE;
         st_high_d = MIS_RESET_VALUE;
         st_high_d[MIS_HIGH_RESET_DONE] = 1'b1;
         en_low_d = MIS_RESET_VALUE;
         en_mid_d = MIS_RESET_VALUE;
         en_high_d = MIS_RESET_VALUE;
      end
      // summary follows the flags of the same edge, so it never lags them
      summary_d = any_enabled(st_low_d, st_mid_d, st_high_d,
                              en_low_d, en_mid_d, en_high_d);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_low_q <= MIS_RESET_VALUE;
         st_mid_q <= MIS_RESET_VALUE;
         st_high_q <= MIS_RESET_VALUE;
         en_low_q <= MIS_RESET_VALUE;
         en_mid_q <= MIS_RESET_VALUE;
         en_high_q <= MIS_RESET_VALUE;
         summary_q <= 1'b0;
         boot_q <= 1'b0;
      end else begin
         st_low_q <= st_low_d;
         st_mid_q <= st_mid_d;
         st_high_q <= st_high_d;
         en_low_q <= en_low_d;
         en_mid_q <= en_mid_d;
         en_high_q <= en_high_d;
         summary_q <= summary_d;
         boot_q <= boot_d;
      end
   end

   // read data is registered; it holds between reads
   always_comb begin
      rdata_d = rdata_q;
      if (sfr_req.rd) begin
         unique case (sfr_req.addr)
            MIS_ADDR_ST_LOW: rdata_d = {summary_q, st_low_q[6:0]};
            MIS_ADDR_ST_MID: rdata_d = st_mid_q;
            MIS_ADDR_ST_HIGH: rdata_d = st_high_q;
            MIS_ADDR_EN_LOW: rdata_d = en_low_q;
            MIS_ADDR_EN_MID: rdata_d = en_mid_q;
            MIS_ADDR_EN_HIGH: rdata_d = en_high_q;
            default: rdata_d = MIS_RDATA_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= MIS_RESET_VALUE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign sfr_rdata = rdata_q;
   assign metering_irq_summary = summary_q;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   logic any_en_now;
   assign any_en_now = any_enabled(st_low_q, st_mid_q, st_high_q,
                                   en_low_q, en_mid_q, en_high_q);

   sequence s_fault_enter;
      !accumulation_config[MIS_ACC_FAULT_POL] && $rose(events.fault_mode) && !soft_reset
      ##1 !soft_reset;
   endsequence

   sequence s_reactive_to_pos;
      accumulation_config[MIS_ACC_REACTIVE_POL] && $fell(events.reactive_negative)
      && !soft_reset ##1 !soft_reset;
   endsequence

   sequence s_active_to_neg;
      !accumulation_config[MIS_ACC_ACTIVE_POL] && $rose(events.active_negative)
      && !soft_reset ##1 !soft_reset;
   endsequence

   a_summary_set: assert property (any_en_now |-> metering_irq_summary)
      else $error("summary low while an enabled flag is set");

   a_summary_clear: assert property (!any_en_now |-> !metering_irq_summary)
      else $error("summary high with no enabled flag set");

   a_fault_flag: assert property (s_fault_enter |=> st_low_q[MIS_LOW_FAULT])
      else $error("fault change flag not set");

   a_reactive_flag: assert property (s_reactive_to_pos |=> st_low_q[MIS_LOW_REACTIVE_SIGN])
      else $error("reactive sign flag not set");

   a_active_flag: assert property (s_active_to_neg |=> st_low_q[MIS_LOW_ACTIVE_SIGN])
      else $error("active sign flag not set");

   a_noload_flags: assert property ((events.irms_noload || events.apparent_noload) && !soft_reset
      |=> st_low_q[MIS_LOW_APPARENT_NOLOAD])
      else $error("apparent no-load flag not set");

   a_freq_b_flag: assert property (events.freq_out_b_pulse && !soft_reset
      |=> st_mid_q[MIS_MID_FREQ_B])
      else $error("second frequency pulse flag not set");

   a_overflow_flags: assert property (!soft_reset
      |=> (st_mid_q[5:3] & $past(events.energy_overflow)) == $past(events.energy_overflow))
      else $error("overflow flag not set");

   a_zero_cross: assert property (events.zero_cross_detect && !soft_reset
      |=> st_high_q[MIS_HIGH_ZX_DETECT]
          ##1 (st_high_q[MIS_HIGH_ZX_DETECT] || $past(sfr_req.wr) || $past(soft_reset)))
      else $error("zero crossing flag not set or not held");

   a_soft_reset: assert property (soft_reset
      |=> st_high_q[MIS_HIGH_RESET_DONE] && st_low_q == 8'h00 && !metering_irq_summary)
      else $error("software reset not marked");

   a_enable_gate: assert property ((en_low_q | en_mid_q | en_high_q) == 8'h00
      |-> !metering_irq_summary)
      else $error("summary raised with all enables clear");

   a_flag_holds: assert property (st_mid_q[MIS_MID_HALF_LSB] && !soft_reset
      && !wr_hit(sfr_req, MIS_ADDR_ST_MID) |=> st_mid_q[MIS_MID_HALF_LSB])
      else $error("flag dropped without a clearing write");

   a_reserved_zero: assert property (sfr_req.rd && sfr_req.addr == MIS_ADDR_ST_LOW
      |=> !sfr_rdata[6])
      else $error("reserved bit read as one");

   sequence s_fault_return;
      accumulation_config[MIS_ACC_FAULT_POL] && $fell(events.fault_mode) && !soft_reset
      ##1 !soft_reset;
   endsequence

   a_fault_return: assert property (s_fault_return |=> st_low_q[MIS_LOW_FAULT])
      else $error("fault return flag not set");

   a_sign_polarity: assert property (!accumulation_config[MIS_ACC_ACTIVE_POL]
      && $fell(events.active_negative) |=> !active_sign_flag)
      else $error("active sign event on the unselected direction");

   a_react_noload: assert property (events.reactive_noload && !soft_reset
      |=> st_low_q[MIS_LOW_REACTIVE_NOLOAD])
      else $error("reactive no-load flag not set");

   a_active_noload: assert property (events.active_noload && !soft_reset
      |=> st_low_q[MIS_LOW_ACTIVE_NOLOAD])
      else $error("active no-load flag not set");

   a_freq_a_flag: assert property (events.freq_out_a_pulse && !soft_reset
      |=> st_mid_q[MIS_MID_FREQ_A])
      else $error("first frequency pulse flag not set");

   a_half_flags: assert property (!soft_reset
      |=> (st_mid_q[2:0] & $past(events.energy_half)) == $past(events.energy_half))
      else $error("half full flag not set");

endmodule

// File: verification/mis_core_model.sv
// core-side model of the special function register bus of the status block.
// assumes the bench calls its tasks one at a time, from the clk domain.
`timescale 1ns/1ps
module mis_core_model
   import mis_pkg::*;
(
   // clock
   input wire logic clk,
   // register bus
   output mis_sfr_req_type sfr_req,
   input wire logic [7:0] sfr_rdata
);
   initial begin
      sfr_req = '{addr: 8'h00, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
   end

   // strobe raised 1 ns after an edge, held for exactly one taking edge
   task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk);
      #1;
      sfr_req.addr = addr;
      sfr_req.wdata = data;
      sfr_req.wr = 1'b1;
      @(posedge clk);
      #1;
      sfr_req.wr = 1'b0;
      // an idle bus must not show the last value, or a sloppy decode would pass
      sfr_req.addr = ~addr;
      sfr_req.wdata = ~data;
   endtask

   task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clk);
      #1;
      sfr_req.addr = addr;
      sfr_req.rd = 1'b1;
      @(posedge clk);
      #1;
      data = sfr_rdata;
      sfr_req.rd = 1'b0;
      sfr_req.addr = ~addr;
   endtask
endmodule

// File: verification/tb_metering_irq_status.sv
// self-checking bench for the metering event status block.
// assumes the core model above is the only bus master; all inputs move 1 ns after clk rises.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin err_total++; \
$display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module tb_metering_irq_status
   import mis_pkg::*;
;
   logic clk;
   logic rst_n;
   logic soft_reset;
   logic [7:0] accumulation_config;
   logic metering_irq_summary;
   logic [7:0] sfr_rdata;
   mis_sfr_req_type sfr_req;
   mis_events_type ev;
   int err_total = 0;
   int n_checks = 0;

   mis_core_model core (.clk(clk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata));

   mis_status dut (
      .clk(clk),
      .rst_n(rst_n),
      .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata),
      .soft_reset(soft_reset),
      .events(ev),
      .accumulation_config(accumulation_config),
      .metering_irq_summary(metering_irq_summary)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex, input string nm);
      logic [7:0] d;
      core.sfr_read(a, d);
      `CHK(nm, ex, d)
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      #1;
      ev[i] = 1'b1;
      @(posedge clk);
      #1;
      ev[i] = 1'b0;
   endtask

   task automatic t_reset();
      rd_chk(MIS_ADDR_ST_HIGH, 8'h80, "high after reset");
      rd_chk(MIS_ADDR_ST_LOW, 8'h00, "low after reset");
      rd_chk(MIS_ADDR_ST_MID, 8'h00, "mid after reset");
      rd_chk(MIS_ADDR_EN_MID, 8'h00, "enable mid after reset");
      rd_chk(8'hD0, 8'h00, "unmapped read");
      core.sfr_write(MIS_ADDR_EN_LOW, 8'hFF);
      rd_chk(MIS_ADDR_EN_LOW, 8'h3F, "enable low reserved");
      core.sfr_write(MIS_ADDR_EN_HIGH, 8'hFF);
      rd_chk(MIS_ADDR_EN_HIGH, 8'h3F, "enable high reserved");
      // summary bit is computed, so writing it must not set it
      core.sfr_write(MIS_ADDR_ST_LOW, 8'hFF);
      rd_chk(MIS_ADDR_ST_LOW, 8'h00, "low write ones");
      core.sfr_write(MIS_ADDR_EN_LOW, 8'h00);
      core.sfr_write(MIS_ADDR_EN_HIGH, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_pulses();
      logic [7:0] a;
      logic [7:0] m;
      int b;
      core.sfr_write(MIS_ADDR_ST_HIGH, 8'h00);
      rd_chk(MIS_ADDR_ST_HIGH, 8'h00, "reset flag cleared");
      for (int i = 0; i < 18; i++) begin
         a = (i < 6) ? MIS_ADDR_ST_HIGH : (i < 14) ? MIS_ADDR_ST_MID : MIS_ADDR_ST_LOW;
         b = (i < 6) ? i : (i < 14) ? i - 6 : (i == 17) ? 2 : i - 14;
         m = 8'h01 << b;
         pulse(i);
         `CHK("summary masked", 1'b0, metering_irq_summary)
         rd_chk(a, m, "flag set");
         core.sfr_write(a - 8'h03, m);
         `CHK("summary raised", 1'b1, metering_irq_summary)
         rd_chk(a, m | ((a == MIS_ADDR_ST_LOW) ? 8'h80 : 8'h00), "flag held");
         core.sfr_write(a, ~m);
         `CHK("summary dropped", 1'b0, metering_irq_summary)
         rd_chk(a, 8'h00, "flag cleared");
         core.sfr_write(a - 8'h03, 8'h00);
      end
      $display("test pulses done");
   endtask

   task automatic t_signs();
      for (int j = 0; j < 3; j++) begin
         for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            #1;
            accumulation_config = 8'h00;
            accumulation_config[6 - j] = p[0];
            repeat (2) @(posedge clk);
            #1;
            ev[20 - j] = 1'b1;
            repeat (3) @(posedge clk);
            #1;
            rd_chk(MIS_ADDR_ST_LOW, p ? 8'h00 : 8'h20 >> j, "rise");
            core.sfr_write(MIS_ADDR_ST_LOW, 8'h00);
            ev[20 - j] = 1'b0;
            repeat (3) @(posedge clk);
            #1;
            rd_chk(MIS_ADDR_ST_LOW, p ? 8'h20 >> j : 8'h00, "fall");
            core.sfr_write(MIS_ADDR_ST_LOW, 8'h00);
         end
      end
      $display("test signs done");
   endtask

   task automatic t_soft();
      core.sfr_write(MIS_ADDR_EN_MID, 8'hFF);
      pulse(12);
      `CHK("summary before soft reset", 1'b1, metering_irq_summary)
      @(posedge clk);
      #1;
      soft_reset = 1'b1;
      @(posedge clk);
      #1;
      soft_reset = 1'b0;
      `CHK("summary after soft reset", 1'b0, metering_irq_summary)
      rd_chk(MIS_ADDR_ST_HIGH, 8'h80, "high after soft reset");
      rd_chk(MIS_ADDR_ST_MID, 8'h00, "mid after soft reset");
      rd_chk(MIS_ADDR_EN_MID, 8'h00, "enable after soft reset");
      $display("test soft reset done");
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      rst_n = 1'b0;
      soft_reset = 1'b0;
      accumulation_config = 8'h00;
      ev = '0;
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_pulses();
      t_signs();
      t_soft();
      print_verdict();
   end

   // tests need about 400 cycles; the limit of 25000 cycles leaves wide margin
   initial begin
      #1000000;
      err_total++;
      print_verdict();
   end
endmodule
